/* design/fsw_write_cmd.sv */
// Contract
// - Byte 0 value 0xB1 marks a write-flash request.
// - Sub-code 0x00 writes chip settings, 0x01 writes GP settings.
// - Sub-codes 0x02..0x04 rewrite manufacturer, product, serial strings.
// - Other sub-codes: no write, unsupported code in response byte 1.
// - Bytes 2..63 are payload whose layout follows the sub-code.
// - Byte 2 bit 7 enables the serial number at enumeration.
// - Byte 2 bit 6 is receive indicator idle level; inverted when active.
// - Byte 2 bit 5 is transmit indicator idle level; inverted when active.
// - Byte 2 bit 4 is two-wire indicator idle level; inverted when active.
// - Byte 2 bit 3 is suspend indicator level; inverted in suspend.
// - Byte 2 bit 2 is configured indicator level; inverted once configured.
// - Byte 2 bits 1-0: 1x locked, 01 password, 00 unsecured.
// - Byte 3 bits 4-0 divide the 48 MHz clock for clock output.
// - Byte 4 bits 7-6 pick internal DAC reference level or off.
// - Byte 4 bit 5 picks supply rail (1) or internal reference (0).
// - Byte 4 bits 4-0 are the DAC power-up code.
module fsw_write_cmd
    import fsw_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire fsw_byte_t rxByte,
    input wire logic uartRxBusy,
    input wire logic uartTxBusy,
    input wire logic twoWireBusy,
    input wire logic twoWireLedEnable,
    input wire logic usbSuspended,
    input wire logic suspendLedEnable,
    input wire logic usbConfigured,
    input wire logic configuredLedEnable,
    input wire logic powerUpLoad,
    output logic rspValid,
    output logic [7:0] rspCode,
    output logic [7:0] rspStatus,
    output logic chipWrite,
    output logic gpWrite,
    output logic [2:0] stringWrite,
    output logic payloadValid,
    output logic [5:0] payloadIndex,
    output logic [7:0] payloadData,
    output fsw_settings_t storedSettings,
    output fsw_settings_t activeSettings,
    output logic rx_activity_indicator,
    output logic tx_activity_indicator,
    output logic twowire_activity_indicator,
    output logic suspend_indicator,
    output logic configured_indicator
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release.
    ////////////////////////////////////////////////////////////////////////

    logic rstMeta_r;
    logic rstSync_r;

    // Releases the reset through two flip-flops.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Report byte tracking.
    ////////////////////////////////////////////////////////////////////////

    // Returns true for a sub-code that this command supports.
    function automatic logic subSupported(input logic [7:0] s);
        subSupported = (s == SUB_CHIP) || (s == SUB_GP) ||
            (s == SUB_MFR_STR) || (s == SUB_PROD_STR) ||
            (s == SUB_SERIAL_STR);
    endfunction : subSupported

    logic [5:0] idx_r;
    logic isWrite_r;
    logic [7:0] sub_r;
    logic [7:0] b2_r;
    logic [7:0] b3_r;
    logic [7:0] b4_r;
    logic subOk;

    // Counts bytes of the report; a last byte restarts the count.
    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            idx_r <= IDX_CMD;
        end else if (rxByte.valid) begin
            if (rxByte.last || idx_r == IDX_LAST) begin
                idx_r <= IDX_CMD;
            end else begin
                idx_r <= idx_r + 6'h01;
            end
        end
    end

    // Captures command code, sub-code and the chip-settings bytes.
    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            isWrite_r <= 1'b0;
            sub_r <= SUB_CHIP;
            b2_r <= B2_RESET;
            b3_r <= B3_RESET;
            b4_r <= B4_RESET;
        end else if (rxByte.valid) begin
            if (idx_r == IDX_CMD) begin
                isWrite_r <= (rxByte.data == CMD_WRITE_FLASH);
            end else if (idx_r == IDX_SUB) begin
                sub_r <= rxByte.data;
            end else if (idx_r == IDX_B2) begin
                b2_r <= rxByte.data;
            end else if (idx_r == IDX_B3) begin
                b3_r <= rxByte.data;
            end else if (idx_r == IDX_B4) begin
                b4_r <= rxByte.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Payload forwarding and write strobes.
    ////////////////////////////////////////////////////////////////////////

    logic endOfReport;
    logic isWriteNext;
    logic [7:0] subNext;
    logic [7:0] b2Next;
    logic [7:0] b3Next;
    logic [7:0] b4Next;
    logic headerOnly;
    logic doWrite;

    assign endOfReport = rxByte.valid && (rxByte.last || idx_r == IDX_LAST);
    // A report may end early; the byte in flight still counts, so a short
    // report never acts on a header left from an earlier report; bytes 2..4 it omits keep their old values.
    assign isWriteNext = (rxByte.valid && idx_r == IDX_CMD) ?
        (rxByte.data == CMD_WRITE_FLASH) : isWrite_r;
    assign subNext = (rxByte.valid && idx_r == IDX_SUB) ? rxByte.data : sub_r;
    assign b2Next = (rxByte.valid && idx_r == IDX_B2) ? rxByte.data : b2_r;
    assign b3Next = (rxByte.valid && idx_r == IDX_B3) ? rxByte.data : b3_r;
    assign b4Next = (rxByte.valid && idx_r == IDX_B4) ? rxByte.data : b4_r;
    // A report that ends on its command byte carries no sub-code at all.
    assign headerOnly = rxByte.valid && idx_r == IDX_CMD;
    assign subOk = subSupported(subNext) && !headerOnly;
    // A supported write request completes with this byte.
    assign doWrite = endOfReport && isWriteNext && subOk;

    // Forwards payload bytes of supported write commands with their index.
    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            payloadValid <= 1'b0;
            payloadIndex <= IDX_CMD;
            payloadData <= 8'h00;
        end else begin
            payloadValid <= rxByte.valid && isWrite_r && subOk &&
                idx_r >= IDX_B2;
            payloadIndex <= idx_r;
            payloadData <= rxByte.data;
        end
    end

    // Issues one write strobe per supported write report, chosen by the sub-code.
    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            chipWrite <= 1'b0;
            gpWrite <= 1'b0;
            stringWrite <= 3'h0;
        end else begin
            chipWrite <= doWrite && subNext == SUB_CHIP;
            gpWrite <= doWrite && subNext == SUB_GP;
            stringWrite <= {doWrite && subNext == SUB_SERIAL_STR,
                doWrite && subNext == SUB_PROD_STR,
                doWrite && subNext == SUB_MFR_STR};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Chip-settings decode into nonvolatile image.
    ////////////////////////////////////////////////////////////////////////

    // Stores decoded chip settings when a chip-settings write completes.
    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            storedSettings <= '0;
        end else if (doWrite && subNext == SUB_CHIP) begin
            storedSettings.serialEnable <= b2Next[B2_SERIAL_EN];
            storedSettings.rxIdle <= b2Next[B2_RX_IDLE];
            storedSettings.txIdle <= b2Next[B2_TX_IDLE];
            storedSettings.twIdle <= b2Next[B2_TW_IDLE];
            storedSettings.suspIdle <= b2Next[B2_SUSP_IDLE];
            storedSettings.cfgIdle <= b2Next[B2_CFG_IDLE];
            storedSettings.secMode <= b2Next[B2_SEC_LSB +: 2];
            // Upper bits of byte 3 are dropped here.
            storedSettings.clkDiv <= b3Next[B3_DIV_LSB +: 5];
            storedSettings.dacVref <= b4Next[B4_VREF_LSB +: 2];
            storedSettings.dacSupplyRef <= b4Next[B4_SRC_BIT];
            storedSettings.dacCode <= b4Next[B4_CODE_LSB +: 5];
        end
    end

    // Copies the stored image into the live settings only on power-up load.
    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            activeSettings <= '0;
        end else if (powerUpLoad) begin
            activeSettings <= storedSettings;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Security mode decode.
    ////////////////////////////////////////////////////////////////////////

    fsw_sec_t secMode;

    // Maps the two live security bits onto the three modes.
    always_comb begin
        case (activeSettings.secMode)
            2'b00: secMode = FSW_SEC_OPEN;
            2'b01: secMode = FSW_SEC_PASSWORD;
            default: secMode = FSW_SEC_LOCKED;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Response report.
    ////////////////////////////////////////////////////////////////////////

    // Answers each write-flash report with echo and status.
    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            rspValid <= 1'b0;
            rspCode <= 8'h00;
            rspStatus <= STAT_OK;
        end else begin
            rspValid <= endOfReport && isWriteNext;
            if (endOfReport && isWriteNext) begin
                rspCode <= CMD_WRITE_FLASH;
                rspStatus <= subOk ? STAT_OK : STAT_UNSUPPORTED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicator pins from live settings.
    ////////////////////////////////////////////////////////////////////////

    // Drives each indicator at its idle level, inverted while active; two-wire, suspend and configured only when their enable is set.
    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            rx_activity_indicator <= 1'b0;
            tx_activity_indicator <= 1'b0;
            twowire_activity_indicator <= 1'b0;
            suspend_indicator <= 1'b0;
            configured_indicator <= 1'b0;
        end else begin
            rx_activity_indicator <=
                activeSettings.rxIdle ^ uartRxBusy;
            tx_activity_indicator <=
                activeSettings.txIdle ^ uartTxBusy;
            twowire_activity_indicator <= activeSettings.twIdle ^
                (twoWireLedEnable && twoWireBusy);
            suspend_indicator <= activeSettings.suspIdle ^
                (suspendLedEnable && usbSuspended);
            configured_indicator <= activeSettings.cfgIdle ^
                (configuredLedEnable && usbConfigured);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////////////

    detect_cmd_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        (endOfReport && isWriteNext) |=> rspValid && rspCode == 8'hB1)
        else $error("write command not answered");

    bad_sub_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        (endOfReport && isWriteNext && !subOk) |=>
            rspStatus == STAT_UNSUPPORTED && !chipWrite && !gpWrite &&
            stringWrite == 3'h0)
        else $error("unsupported sub-code wrote or passed");

    chip_strobe_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        chipWrite |-> $past(subNext) == SUB_CHIP && rspValid)
        else $error("chip write without chip sub-code");

    string_strobe_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        stringWrite[1] |-> $past(subNext) == SUB_PROD_STR)
        else $error("product string write with wrong sub-code");

    payload_idx_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        payloadValid |-> payloadIndex >= IDX_B2)
        else $error("header byte forwarded as payload");

    store_fields_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        chipWrite |-> storedSettings.serialEnable == $past(b2Next[7]) &&
            storedSettings.secMode == $past(b2Next[1:0]))
        else $error("byte 2 fields not stored");

    gp_strobe_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        gpWrite |-> $past(subNext) == SUB_GP && rspValid &&
            rspStatus == STAT_OK)
        else $error("pin settings write without its sub-code");

    clk_div_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        chipWrite |-> storedSettings.clkDiv == $past(b3Next[4:0]))
        else $error("clock divider not stored");

    dac_fields_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        chipWrite |-> {storedSettings.dacVref, storedSettings.dacSupplyRef,
            storedSettings.dacCode} == $past(b4Next))
        else $error("DAC fields not stored");

    tx_led_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        $past(uartTxBusy) && $stable(activeSettings) |->
            tx_activity_indicator == !activeSettings.txIdle)
        else $error("transmit indicator not inverted while busy");

    rx_led_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        $past(uartRxBusy) && $stable(activeSettings) |->
            rx_activity_indicator == !activeSettings.rxIdle)
        else $error("receive indicator not inverted while busy");

    susp_led_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        !$past(suspendLedEnable) && $stable(activeSettings) |->
            suspend_indicator == activeSettings.suspIdle)
        else $error("disabled suspend indicator left idle level");

    defer_load_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        !$past(powerUpLoad) |-> $stable(activeSettings))
        else $error("live settings changed without power-up load");

    sec_lock_a: assert property (
        @(posedge mclk) disable iff (!rstSync_r)
        activeSettings.secMode[1] |-> secMode == FSW_SEC_LOCKED)
        else $error("security bits 1x not locked");

endmodule : fsw_write_cmd

/* inc/fsw_pkg.sv */
package fsw_pkg;

    // Command and sub-code values.
    localparam logic [7:0] CMD_WRITE_FLASH = 8'hB1;
    localparam logic [7:0] SUB_CHIP = 8'h00;
    localparam logic [7:0] SUB_GP = 8'h01;
    localparam logic [7:0] SUB_MFR_STR = 8'h02;
    localparam logic [7:0] SUB_PROD_STR = 8'h03;
    localparam logic [7:0] SUB_SERIAL_STR = 8'h04;

    // Response status codes.
    localparam logic [7:0] STAT_OK = 8'h00;
    localparam logic [7:0] STAT_UNSUPPORTED = 8'h02;

    // Report geometry.
    localparam int REPORT_BYTES = 64;
    localparam logic [5:0] IDX_CMD = 6'h00;
    localparam logic [5:0] IDX_SUB = 6'h01;
    localparam logic [5:0] IDX_B2 = 6'h02;
    localparam logic [5:0] IDX_B3 = 6'h03;
    localparam logic [5:0] IDX_B4 = 6'h04;
    localparam logic [5:0] IDX_LAST = 6'h3F;

    // Byte 2 field positions.
    localparam int B2_SERIAL_EN = 7;
    localparam int B2_RX_IDLE = 6;
    localparam int B2_TX_IDLE = 5;
    localparam int B2_TW_IDLE = 4;
    localparam int B2_SUSP_IDLE = 3;
    localparam int B2_CFG_IDLE = 2;
    localparam int B2_SEC_LSB = 0;
    // Byte 3 and byte 4 field positions.
    localparam int B3_DIV_LSB = 0;
    localparam int B4_VREF_LSB = 6;
    localparam int B4_SRC_BIT = 5;
    localparam int B4_CODE_LSB = 0;

    // Reset value of the captured chip-settings bytes 2 to 4.
    localparam logic [7:0] B2_RESET = 8'h00;
    localparam logic [7:0] B3_RESET = 8'h00;
    localparam logic [7:0] B4_RESET = 8'h00;

    // Security modes.
    typedef enum logic [1:0] {
        FSW_SEC_OPEN, FSW_SEC_PASSWORD, FSW_SEC_LOCKED
    } fsw_sec_t;

    // Decoded chip settings.
    typedef struct packed {
        logic serialEnable;
        logic rxIdle;
        logic txIdle;
        logic twIdle;
        logic suspIdle;
        logic cfgIdle;
        logic [1:0] secMode;
        logic [4:0] clkDiv;
        logic [1:0] dacVref;
        logic dacSupplyRef;
        logic [4:0] dacCode;
    } fsw_settings_t;

    // Incoming report byte.
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } fsw_byte_t;

endpackage : fsw_pkg

/* test/fsw_host_model.sv */
module fsw_host_model
    import fsw_pkg::*;
(
    input wire logic mclk,
    output fsw_byte_t rxByte
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////
    // The line starts released, with no byte offered.
    initial begin
        rxByte = '0;
    end

    // Sends one report a byte per cycle, then releases the line.
    // Released data is inverted so that stale bytes are never reused.
    task automatic send(input logic [7:0] b[$]);
        for (int i = 0; i < b.size(); i++) begin
            @(posedge mclk);
            #5;
            rxByte.valid = 1'b1;
            rxByte.last = (i == b.size() - 1);
            rxByte.data = b[i];
        end
        @(posedge mclk);
        #5;
        rxByte.valid = 1'b0;
        rxByte.last = 1'b0;
        rxByte.data = ~rxByte.data;
    endtask : send
endmodule : fsw_host_model

/* test/tb.sv */
module tb
    import fsw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk, resetn, uartRxBusy, uartTxBusy, twoWireBusy;
    logic twoWireLedEnable, usbSuspended, suspendLedEnable;
    logic usbConfigured, configuredLedEnable, powerUpLoad;
    logic rspValid, chipWrite, gpWrite, payloadValid;
    logic [7:0] rspCode, rspStatus, payloadData, gotCode, gotStat;
    logic [2:0] stringWrite, strAcc;
    logic [5:0] payloadIndex;
    logic rxInd, txInd, twInd, suspInd, cfgInd;
    fsw_byte_t rxByte;
    fsw_settings_t storedSettings, activeSettings, expStored, expActive;
    logic [7:0] curQ[$];
    int errors, n_compared, rspCnt, payCnt, chipCnt, gpCnt;

    fsw_host_model u_fsw_host_model (.mclk(mclk), .rxByte(rxByte));

    fsw_write_cmd u_fsw_write_cmd (
        .mclk(mclk), .resetn(resetn), .rxByte(rxByte),
        .uartRxBusy(uartRxBusy), .uartTxBusy(uartTxBusy),
        .twoWireBusy(twoWireBusy), .twoWireLedEnable(twoWireLedEnable),
        .usbSuspended(usbSuspended), .suspendLedEnable(suspendLedEnable),
        .usbConfigured(usbConfigured),
        .configuredLedEnable(configuredLedEnable),
        .powerUpLoad(powerUpLoad), .rspValid(rspValid), .rspCode(rspCode),
        .rspStatus(rspStatus), .chipWrite(chipWrite), .gpWrite(gpWrite),
        .stringWrite(stringWrite), .payloadValid(payloadValid),
        .payloadIndex(payloadIndex), .payloadData(payloadData),
        .storedSettings(storedSettings), .activeSettings(activeSettings),
        .rx_activity_indicator(rxInd), .tx_activity_indicator(txInd),
        .twowire_activity_indicator(twInd), .suspend_indicator(suspInd),
        .configured_indicator(cfgInd)
    );

    ////////////////////////////////////////////////////////////////////////
    // The clock runs at 10 MHz.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Comparisons of bytes, single bits and whole settings images.
    task automatic cmp_byte(input string what, input logic [7:0] e,
                            input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_byte

    task automatic cmp_bit(input string what, input logic e, input logic g);
        cmp_byte(what, {7'h00, e}, {7'h00, g});
    endtask : cmp_bit

    // Locked modes 11 and 10 are one mode, so bit 0 is dropped there.
    task automatic cmp_set(input string what, input fsw_settings_t e,
                           input fsw_settings_t g);
        n_compared++;
        if (e.secMode[1]) e.secMode[0] = 1'b0;
        if (g.secMode[1] === 1'b1) g.secMode[0] = 1'b0;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_set

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////
    // Collects the design's pulses and checks each payload byte in order.
    always @(posedge mclk) begin
        if (rspValid === 1'b1) begin
            rspCnt++;
            gotCode = rspCode;
            gotStat = rspStatus;
        end
        if (chipWrite === 1'b1) chipCnt++;
        if (gpWrite === 1'b1) gpCnt++;
        strAcc = strAcc | stringWrite;
        if (payloadValid === 1'b1) begin
            if (payCnt + 2 < curQ.size()) begin
                cmp_byte("payloadIndex", 8'(payCnt + 2),
                         {2'b00, payloadIndex});
                cmp_byte("payloadData", curQ[payCnt + 2],
                         payloadData);
            end
            payCnt++;
        end
    end

    // Sends one report and checks the response, strobes and stored image.
    task automatic run_report(input logic [7:0] b0, input logic [7:0] sub,
                              input int n, input logic [7:0] b2,
                              input logic [7:0] b4);
        logic isCmd;
        logic sup;
        logic [2:0] expStr;
        curQ = {b0, sub, b2, 8'($urandom), b4};
        while (curQ.size() < n) curQ.push_back(8'($urandom));
        while (curQ.size() > n) void'(curQ.pop_back());
        {rspCnt, payCnt, chipCnt, gpCnt} = '0;
        strAcc = 3'h0;
        u_fsw_host_model.send(curQ);
        repeat (3) @(posedge mclk);
        #5;
        isCmd = (b0 == CMD_WRITE_FLASH);
        sup = isCmd && (sub <= SUB_SERIAL_STR);
        expStr = (sup && sub >= SUB_MFR_STR) ?
            3'(1 << (sub - SUB_MFR_STR)) : 3'h0;
        cmp_byte("responses", {7'h00, isCmd}, 8'(rspCnt));
        if (isCmd) begin
            cmp_byte("rspCode", CMD_WRITE_FLASH, gotCode);
            cmp_byte("rspStatus", sup ? STAT_OK : STAT_UNSUPPORTED,
                     gotStat);
        end
        cmp_byte("chipWrite", {7'h00, sup && sub == SUB_CHIP},
                 8'(chipCnt));
        cmp_byte("gpWrite", {7'h00, sup && sub == SUB_GP},
                 8'(gpCnt));
        cmp_byte("stringWrite", {5'h00, expStr}, {5'h00, strAcc});
        cmp_byte("payloads", sup ? 8'(n - 2) : 8'h00,
                 8'(payCnt));
        if (sup && sub == SUB_CHIP) begin
            expStored = {curQ[2], curQ[3][4:0], curQ[4]};
        end
        cmp_set("storedSettings", expStored,
                storedSettings);
        cmp_set("activeSettings", expActive, activeSettings);
        $display("test report %h sub %h done", b0, sub);
    endtask : run_report

    // Randomises the activity inputs and checks all five indicators.
    task automatic check_ind;
        @(posedge mclk);
        #5;
        {uartRxBusy, uartTxBusy, twoWireBusy, twoWireLedEnable} = 4'($urandom);
        {usbSuspended, suspendLedEnable} = 2'($urandom);
        {usbConfigured, configuredLedEnable} = 2'($urandom);
        repeat (3) @(posedge mclk);
        #5;
        cmp_bit("rxInd", expActive.rxIdle ^ uartRxBusy, rxInd);
        cmp_bit("txInd", expActive.txIdle ^ uartTxBusy, txInd);
        cmp_bit("twInd", expActive.twIdle ^
                (twoWireLedEnable & twoWireBusy), twInd);
        cmp_bit("suspInd", expActive.suspIdle ^
                (suspendLedEnable & usbSuspended), suspInd);
        cmp_bit("cfgInd", expActive.cfgIdle ^
                (configuredLedEnable & usbConfigured), cfgInd);
    endtask : check_ind

    // Pulses the power-up load and checks that the live image follows.
    task automatic power_up;
        @(posedge mclk);
        #5;
        powerUpLoad = 1'b1;
        @(posedge mclk);
        #5;
        powerUpLoad = 1'b0;
        expActive = expStored;
        repeat (3) @(posedge mclk);
        #5;
        cmp_set("activeSettings", expActive, activeSettings);
        repeat (4) check_ind();
        $display("test power-up load done");
    endtask : power_up

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {uartRxBusy, uartTxBusy, twoWireBusy, twoWireLedEnable} = 4'h0;
        {usbSuspended, suspendLedEnable, usbConfigured} = 3'h0;
        {configuredLedEnable, powerUpLoad, resetn} = 3'h0;
        {errors, n_compared, rspCnt, payCnt, chipCnt, gpCnt} = '0;
        strAcc = 3'h0;
        expStored = '0;
        expActive = '0;
        void'($urandom(32'h55E6EFEE));
        repeat (10) @(posedge mclk);
        #5;
        resetn = 1'b1;
        repeat (3) @(posedge mclk);
        #5;
        cmp_set("storedSettings", expStored, storedSettings);
        check_ind();
        for (int k = 0; k < 4; k++) begin
            run_report(CMD_WRITE_FLASH, SUB_CHIP, (k == 3) ? 64 : 5 + k * 19,
                       {6'($urandom), 2'(k)},
                       {2'(k), 6'($urandom)});
            check_ind();
        end
        power_up();
        foreach (curQ[i]) curQ[i] = 8'h00;
        for (int s = 1; s < 8; s++) begin
            run_report(CMD_WRITE_FLASH, (s < 5) ? 8'(s) : 8'(s * 40 + 5),
                       6 + s * 7, 8'($urandom),
                       8'($urandom));
        end
        run_report(8'hB0, SUB_CHIP, 8, 8'hFF, 8'hFF);
        run_report(CMD_WRITE_FLASH, SUB_CHIP, 5, 8'($urandom),
                   8'($urandom));
        run_report(CMD_WRITE_FLASH, 8'hCD, 2, 8'h00, 8'h00);
        check_ind();
        power_up();
        report_and_stop();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        report_and_stop();
    end
endmodule : tb
